// ### rtct_countdown.sv
// countdown timer with wishbone registers, flag, level/pulse interrupt
// Function
// - source select picks tick, defaults to sixtieth Hz
// - interrupt enable bit defaults off, gates int_n
// - mode bit picks level or pulse interrupt
// - 8-bit reload, zero stops the timer
// - decrement from one sets flag and reloads
// - reload write takes effect immediately
// - first period after enable may be shorter
// - flag stays set until software clears it
// - int_n is level or pulse, gated by enable
// - count read returns live count
// - slow sources include offset correction steps
// - pulse width depends on source, and on reload for the two fast sources
// - flag and interrupt rise in same cycle
//
// The Wishbone slave port is this design's own decision.
module rtct_countdown
    import rtct_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    input  wire logic        osc_in,
    input  wire logic        corr_insert,
    input  wire logic        corr_remove,
    output logic             int_n,
    output logic             irq
);
    if (CNT_W != 8)
    begin : g_bad_width
        $error("rtct_countdown: counter width must be 8");
    end

    rtct_tick_if ticks ();

    rtct_prescaler u_prescaler
    (
        .clk         (clk),
        .rst         (rst),
        .osc_in      (osc_in),
        .corr_insert (corr_insert),
        .corr_remove (corr_remove),
        .ticks       (ticks)
    );

    logic [7:0]  mode_reg, next_mode_reg;
    logic [7:0]  reload, next_reload;
    logic [7:0]  count, next_count;
    logic        flag, next_flag;
    logic        armed, next_armed;
    logic        pulse_on, next_pulse_on;
    rtct_end_t   pulse_end, next_pulse_end;
    logic [7:0]  irq_stat, next_irq_stat;
    logic [7:0]  irq_mask, next_irq_mask;
    logic [31:0] next_dat_r;
    logic        next_ack, next_int_n, next_irq;

    logic        access, wr, rd, wr_lane0;
    logic [5:0]  idx;
    logic        wr_value, wr_mode;
    rtct_src_t   src;
    logic        run, ie, pmode;
    logic        sel_tick, step, wrap, end_tick;

    function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] b);
        reg_hit = (a == b);
    endfunction

    always_comb
    begin
        // bus decode; one-cycle answer, no waits
        access   = wb_cyc && wb_stb && !wb_ack;
        wr       = access && wb_we;
        rd       = access && !wb_we;
        idx      = wb_adr[7:2];
        wr_lane0 = wr && wb_sel[0];
        wr_value = wr_lane0 && reg_hit(idx, RTCT_IDX_VALUE);
        wr_mode  = wr_lane0 && reg_hit(idx, RTCT_IDX_MODE);

        src   = rtct_src_t'(mode_reg[RTCT_MODE_SRC_HI:RTCT_MODE_SRC_LO]);
        run   = mode_reg[RTCT_MODE_RUN];
        ie    = mode_reg[RTCT_MODE_IE];
        pmode = mode_reg[RTCT_MODE_PULSE];

        unique case (src)
            RTCT_SRC_4096: sel_tick = ticks.tick_4096;
            RTCT_SRC_64:   sel_tick = ticks.tick_64;
            RTCT_SRC_1:    sel_tick = ticks.tick_1;
            RTCT_SRC_60TH: sel_tick = ticks.tick_60th;
        endcase

        next_mode_reg = wr_mode ? (wb_dat_w[7:0] & RTCT_MODE_MASK) : mode_reg;

        // slow sources wait for one 64 Hz step after enable
        if (!run)
            next_armed = 1'b0;
        else if (src == RTCT_SRC_4096 || src == RTCT_SRC_64)
            next_armed = 1'b1;
        else
            next_armed = armed || ticks.tick_64;

        // reload of zero parks the counter
        step = run && armed && sel_tick && (reload != 8'h00);
        wrap = step && (count <= 8'h01);

        next_reload = wr_value ? wb_dat_w[7:0] : reload;
        if (wr_value)
            next_count = wb_dat_w[7:0];
        else if (wrap)
            next_count = reload;
        else if (step)
            next_count = count - 8'h01;
        else
            next_count = count;

        // set wins over a clear in the same cycle
        next_flag = wrap || (flag && !(wr_lane0 && reg_hit(idx, RTCT_IDX_CTL2)
                                       && !wb_dat_w[RTCT_CTL2_FLAG]));

        // pulse width follows source, and reload value for the two fast sources
        unique case (pulse_end)
            RTCT_END_8192: end_tick = ticks.tick_8192;
            RTCT_END_4096: end_tick = ticks.tick_4096;
            RTCT_END_128:  end_tick = ticks.tick_128;
            RTCT_END_64:   end_tick = ticks.tick_64;
        endcase
        next_pulse_end = pulse_end;
        if (wrap)
        begin
            next_pulse_on = 1'b1;
            unique case (src)
                RTCT_SRC_4096: next_pulse_end = (reload == 8'h01) ? RTCT_END_8192
                                                                  : RTCT_END_4096;
                RTCT_SRC_64:   next_pulse_end = (reload == 8'h01) ? RTCT_END_128
                                                                  : RTCT_END_64;
                RTCT_SRC_1,
                RTCT_SRC_60TH: next_pulse_end = RTCT_END_64;
            endcase
        end
        else if (pulse_on && end_tick)
            next_pulse_on = 1'b0;
        else
            next_pulse_on = pulse_on;

        // computed from next values so flag and pin move together
        next_int_n = !(next_mode_reg[RTCT_MODE_IE]
                       && (next_mode_reg[RTCT_MODE_PULSE] ? next_pulse_on
                                                          : next_flag));

        next_irq_mask = (wr_lane0 && reg_hit(idx, RTCT_IDX_IRQ_MASK)) ? wb_dat_w[7:0]
                                                                       : irq_mask;
        next_irq_stat = irq_stat;
        if (rd && reg_hit(idx, RTCT_IDX_IRQ_STAT))
            next_irq_stat = 8'h00;
        if (wrap)
            next_irq_stat[RTCT_EV_PERIOD] = 1'b1;
        next_irq = |(next_irq_stat & next_irq_mask);

        // live count, not frozen during the read
        next_dat_r = 32'h0000_0000;
        if (rd)
        begin
            unique case (1'b1)
                reg_hit(idx, RTCT_IDX_CTL2):     next_dat_r[RTCT_CTL2_FLAG] = flag;
                reg_hit(idx, RTCT_IDX_VALUE):    next_dat_r[7:0] = count;
                reg_hit(idx, RTCT_IDX_MODE):     next_dat_r[7:0] = mode_reg;
                reg_hit(idx, RTCT_IDX_IRQ_STAT): next_dat_r[7:0] = irq_stat;
                reg_hit(idx, RTCT_IDX_IRQ_MASK): next_dat_r[7:0] = irq_mask;
                default:                         next_dat_r = 32'h0000_0000;
            endcase
        end
        next_ack = access;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_reg  <= RTCT_MODE_RESET;
            reload    <= RTCT_VALUE_RESET;
            count     <= RTCT_VALUE_RESET;
            flag      <= 1'b0;
            armed     <= 1'b0;
            pulse_on  <= 1'b0;
            pulse_end <= RTCT_END_64;
            irq_stat  <= RTCT_IRQ_RESET;
            irq_mask  <= RTCT_IRQ_RESET;
            wb_dat_r  <= 32'h0000_0000;
            wb_ack    <= 1'b0;
            int_n     <= 1'b1;
            irq       <= 1'b0;
        end
        else
        begin
            mode_reg  <= next_mode_reg;
            reload    <= next_reload;
            count     <= next_count;
            flag      <= next_flag;
            armed     <= next_armed;
            pulse_on  <= next_pulse_on;
            pulse_end <= next_pulse_end;
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            wb_dat_r  <= next_dat_r;
            wb_ack    <= next_ack;
            int_n     <= next_int_n;
            irq       <= next_irq;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_flag_sticky: assert property (
        flag && !(wr_lane0 && reg_hit(idx, RTCT_IDX_CTL2)) |=> flag)
        else $error("countdown flag dropped without a clear");

    a_wrap_reload: assert property (
        wrap && !wr_value |=> (count == $past(reload)) && flag && irq_stat[RTCT_EV_PERIOD])
        else $error("period end did not reload and flag");

    a_count_step: assert property (
        step && !wrap && !wr_value |=> count == $past(count) - 8'h01)
        else $error("counter did not decrement by one");

    a_hold_stopped: assert property (
        !run && !wr_value |=> $stable(count) && !$rose(flag))
        else $error("counter moved while stopped");

    a_zero_parks: assert property (
        reload == 8'h00 && !wr_value |=> !$rose(flag))
        else $error("zero reload still produced a period end");

    a_write_now: assert property (
        wr_value |=> count == $past(wb_dat_w[7:0]) && reload == $past(wb_dat_w[7:0]))
        else $error("reload write not applied at once");

    a_irq_gated: assert property (
        !ie |-> int_n)
        else $error("interrupt pin active while disabled");

    a_level_follow: assert property (
        ie && !pmode |-> int_n == !flag)
        else $error("level interrupt does not follow flag");

    a_rise_together: assert property (
        $rose(flag) && ie |-> !int_n)
        else $error("flag and interrupt pin not simultaneous");

    a_tick_only: assert property (
        !sel_tick && !wr_value |=> $stable(count))
        else $error("counter moved without a source tick");

    a_read_live: assert property (
        rd && reg_hit(idx, RTCT_IDX_VALUE) |=> wb_ack && wb_dat_r[7:0] == $past(count))
        else $error("count read does not show live value");

    a_status_irq: assert property (
        wrap ##1 irq_mask[RTCT_EV_PERIOD] |-> irq)
        else $error("unmasked period event did not raise irq");

    a_pulse_start: assert property (
        wrap |=> pulse_on)
        else $error("period end did not start the pulse");

    a_pulse_end: assert property (
        pulse_on && end_tick && !wrap |=> !pulse_on)
        else $error("pulse did not end on its width tick");

    a_pulse_pin: assert property (
        ie && pmode |-> int_n == !pulse_on)
        else $error("pulse interrupt does not follow pulse");

    a_disarm_stop: assert property (
        !run |=> !armed)
        else $error("timer stayed armed while stopped");

    a_flag_clear: assert property (
        wr_lane0 && reg_hit(idx, RTCT_IDX_CTL2) && !wb_dat_w[RTCT_CTL2_FLAG] && !wrap
        |=> !flag)
        else $error("flag clear by software not applied");

    a_stat_clear: assert property (
        rd && reg_hit(idx, RTCT_IDX_IRQ_STAT) && !wrap |=> !irq_stat[RTCT_EV_PERIOD])
        else $error("status read did not clear the event bit");

    a_ack_pulse: assert property (
        wb_ack |=> !wb_ack)
        else $error("bus acknowledge longer than one cycle");

    a_dat_quiet: assert property (
        !wb_ack |-> wb_dat_r == 32'h0000_0000)
        else $error("read data not zero outside acknowledge");
endmodule

// ### rtct_pkg.sv
// shared constants and types for the countdown timer
package rtct_pkg;

    // register indexes; byte address is four times the index
    localparam logic [5:0] RTCT_IDX_CTL2      = 6'h01;
    localparam logic [5:0] RTCT_IDX_VALUE     = 6'h10;
    localparam logic [5:0] RTCT_IDX_MODE      = 6'h11;
    localparam logic [5:0] RTCT_IDX_IRQ_STAT  = 6'h12;
    localparam logic [5:0] RTCT_IDX_IRQ_MASK  = 6'h13;

    // mode register layout
    localparam int         RTCT_MODE_SRC_HI   = 4;
    localparam int         RTCT_MODE_SRC_LO   = 3;
    localparam int         RTCT_MODE_RUN      = 2;
    localparam int         RTCT_MODE_IE       = 1;
    localparam int         RTCT_MODE_PULSE    = 0;
    localparam logic [7:0] RTCT_MODE_RESET    = 8'h18;
    localparam logic [7:0] RTCT_MODE_MASK     = 8'h1f;

    // second control register: countdown flag position
    localparam int         RTCT_CTL2_FLAG     = 3;

    // status / mask layout
    localparam int         RTCT_EV_PERIOD     = 0;
    localparam logic [7:0] RTCT_IRQ_RESET     = 8'h00;

    localparam logic [7:0] RTCT_VALUE_RESET   = 8'h00;

    // tap masks on the oscillator edge count, and slow chain terminal counts
    localparam logic [8:0] RTCT_TAP_8192      = 9'h003;
    localparam logic [8:0] RTCT_TAP_4096      = 9'h007;
    localparam logic [8:0] RTCT_TAP_128       = 9'h0ff;
    localparam logic [8:0] RTCT_TAP_64        = 9'h1ff;
    localparam logic [5:0] RTCT_STEPS_PER_SEC = 6'h3f;
    localparam logic [5:0] RTCT_SECS_PER_MIN  = 6'h3b;

    typedef enum logic [1:0]
    {
        RTCT_SRC_4096,
        RTCT_SRC_64,
        RTCT_SRC_1,
        RTCT_SRC_60TH
    } rtct_src_t;

    typedef enum logic [1:0]
    {
        RTCT_END_8192,
        RTCT_END_4096,
        RTCT_END_128,
        RTCT_END_64
    } rtct_end_t;

endpackage

// ### rtct_tick_if.sv
// tick strobes from the prescaler to the countdown logic
interface rtct_tick_if;
    logic tick_8192;
    logic tick_4096;
    logic tick_128;
    logic tick_64;
    logic tick_1;
    logic tick_60th;

    modport src (output tick_8192, tick_4096, tick_128, tick_64, tick_1, tick_60th);
    modport snk (input  tick_8192, tick_4096, tick_128, tick_64, tick_1, tick_60th);
endinterface

// ### rtct_prescaler.sv
// oscillator synchroniser and tap divider with offset correction on the slow chain
module rtct_prescaler
    import rtct_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic osc_in,
    input  wire logic corr_insert,
    input  wire logic corr_remove,
    rtct_tick_if.src  ticks
);
    logic       sync1, sync2, sync3, osc_lvl;
    logic       next_osc_lvl;
    logic [8:0] div, next_div;
    logic [5:0] step, next_step;
    logic [5:0] secs, next_secs;
    logic       edge_seen;
    logic       adv64;
    logic       sec_wrap;
    logic       next_t8192, next_t4096, next_t128, next_t64, next_t1, next_t60;

    function automatic logic at_tap(input logic [8:0] cnt, input logic [8:0] tap);
        at_tap = (cnt & tap) == tap;
    endfunction

    always_comb
    begin
        // a change counts only once the second and third stage agree
        next_osc_lvl = (sync2 == sync3) ? sync3 : osc_lvl;
        edge_seen    = next_osc_lvl && !osc_lvl;
        next_div     = edge_seen ? div + 9'h001 : div;
        next_t8192   = edge_seen && at_tap(div, RTCT_TAP_8192);
        next_t4096   = edge_seen && at_tap(div, RTCT_TAP_4096);
        next_t128    = edge_seen && at_tap(div, RTCT_TAP_128);
        next_t64     = edge_seen && at_tap(div, RTCT_TAP_64);
        // correction only touches the 1 Hz chain; fast taps stay exact
        adv64        = (next_t64 && !corr_remove) || (!next_t64 && corr_insert);
        sec_wrap     = adv64 && (step == RTCT_STEPS_PER_SEC);
        next_step    = adv64 ? step + 6'h01 : step;
        next_t1      = sec_wrap;
        next_t60     = sec_wrap && (secs == RTCT_SECS_PER_MIN);
        next_secs    = sec_wrap ? ((secs == RTCT_SECS_PER_MIN) ? 6'h00 : secs + 6'h01) : secs;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1           <= 1'b0;
            sync2           <= 1'b0;
            sync3           <= 1'b0;
            osc_lvl         <= 1'b0;
            div             <= 9'h000;
            step            <= 6'h00;
            secs            <= 6'h00;
            ticks.tick_8192 <= 1'b0;
            ticks.tick_4096 <= 1'b0;
            ticks.tick_128  <= 1'b0;
            ticks.tick_64   <= 1'b0;
            ticks.tick_1    <= 1'b0;
            ticks.tick_60th <= 1'b0;
        end
        else
        begin
            sync1           <= osc_in;
            sync2           <= sync1;
            sync3           <= sync2;
            osc_lvl         <= next_osc_lvl;
            div             <= next_div;
            step            <= next_step;
            secs            <= next_secs;
            ticks.tick_8192 <= next_t8192;
            ticks.tick_4096 <= next_t4096;
            ticks.tick_128  <= next_t128;
            ticks.tick_64   <= next_t64;
            ticks.tick_1    <= next_t1;
            ticks.tick_60th <= next_t60;
        end
    end
endmodule

// ### tb_top.sv
// self-checking bench for the countdown timer block
module tb_top
    import rtct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic        wb_cyc      = 1'b0;
    logic        wb_stb      = 1'b0;
    logic        wb_we       = 1'b0;
    logic [7:0]  wb_adr      = 8'h00;
    logic [3:0]  wb_sel      = 4'h1;
    logic [31:0] wb_dat_w    = 32'h00000000;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        osc_in      = 1'b0;
    logic        corr_insert = 1'b0;
    logic        corr_remove = 1'b0;
    logic        int_n;
    logic        irq;
    int          error_cnt   = 0;
    int          tests_run   = 0;
    int          cyc_cnt     = 0;
    int          osc_cnt     = 0;
    int          mdl_mode    = RTCT_MODE_RESET;
    logic [5:0]  rst_idx[6]  = '{RTCT_IDX_CTL2, RTCT_IDX_VALUE, RTCT_IDX_MODE,
                                 RTCT_IDX_IRQ_STAT, RTCT_IDX_IRQ_MASK, 6'h3f};
    logic [7:0]  rst_exp[6]  = '{8'h00, RTCT_VALUE_RESET, RTCT_MODE_RESET,
                                 RTCT_IRQ_RESET, RTCT_IRQ_RESET, 8'h00};

    rtct_countdown #(.CNT_W(8)) i_dut
    (
        .clk         (clk),
        .rst         (rst),
        .wb_cyc      (wb_cyc),
        .wb_stb      (wb_stb),
        .wb_we       (wb_we),
        .wb_adr      (wb_adr),
        .wb_sel      (wb_sel),
        .wb_dat_w    (wb_dat_w),
        .wb_dat_r    (wb_dat_r),
        .wb_ack      (wb_ack),
        .osc_in      (osc_in),
        .corr_insert (corr_insert),
        .corr_remove (corr_remove),
        .int_n       (int_n),
        .irq         (irq)
    );

    always #50 clk = ~clk;

    // fast stand-in oscillator keeps the run short; correction pulses only touch slow chain
    always @(posedge clk)
    begin
        osc_cnt     <= (osc_cnt + 1) % 8;
        osc_in      <= (osc_cnt == 7) ? ~osc_in : osc_in;
        corr_insert <= ($urandom_range(99) == 0);
        corr_remove <= ($urandom_range(99) == 1);
        cyc_cnt     <= cyc_cnt + 1;
        if (cyc_cnt == 90000)
        begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction

    task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= {idx, 2'b00};
        wb_dat_w <= {24'h000000, d};
        // no answer time assumed; only the global timeout ends this wait
        do
        begin
            @(posedge clk);
        end
        while (wb_ack !== 1'b1);
        q = wb_dat_r[7:0];
        check(wb_dat_r[31:8], 24'h000000);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        if (idx == RTCT_IDX_MODE)
            mdl_mode = d & RTCT_MODE_MASK;
        bus(1'b1, idx, d, q);
    endtask

    // waits for int_n at a level, counting edges; a hang counts as a mismatch
    task automatic wait_int(input logic lv, input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (int_n !== lv && n < lim);
        if (n >= lim)
        begin
            check(1'b0, 1'b1);
            conclude();
        end
    endtask

    // an old pulse may still be low and the first period is uncertain:
    // wait for the pin to idle, then take the period between first and second pulse
    task automatic measure(input logic [7:0] t, input logic [7:0] mode, input int lim,
                           output int w, output int p);
        int n;
        wr(RTCT_IDX_VALUE, t);
        wr(RTCT_IDX_MODE, mode);
        wait_int(1'b1, lim, n);
        wait_int(1'b0, lim, n);
        wait_int(1'b1, lim, w);
        wait_int(1'b0, lim, n);
        p = w + n;
    endtask

    initial
    begin
        logic [7:0] q;
        logic [7:0] a;
        int         n;
        int         p1;
        int         w1;
        int         p3;
        int         w3;
        int         p64;
        int         w64;
        void'($urandom(32'h4f9f245e));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rst_idx[i])
        begin
            bus(1'b0, rst_idx[i], 8'h00, q);
            check(q, rst_exp[i]);
        end
        check(int_n, 1'b1);
        for (int s = 0; s < 4; s++)
        begin
            a = 8'($urandom) & 8'hfb;
            a[4:3] = s[1:0];
            wr(RTCT_IDX_MODE, a);
            bus(1'b0, RTCT_IDX_MODE, 8'h00, q);
            check(q, mdl_mode);
            check(int_n, 1'b1);
        end
        wr(RTCT_IDX_MODE, 8'h00);
        wr(RTCT_IDX_VALUE, 8'h05);
        repeat (400) @(posedge clk);
        bus(1'b0, RTCT_IDX_VALUE, 8'h00, q);
        check(q, 8'h05);
        wr(RTCT_IDX_VALUE, 8'h00);
        wr(RTCT_IDX_MODE, 8'h04);
        repeat (400) @(posedge clk);
        bus(1'b0, RTCT_IDX_CTL2, 8'h00, q);
        check(q[RTCT_CTL2_FLAG], 1'b0);
        wr(RTCT_IDX_VALUE, 8'h01);
        wr(RTCT_IDX_MODE, 8'h06);
        wait_int(1'b0, 2000, n);
        check(irq, 1'b0);
        wr(RTCT_IDX_MODE, 8'h02);
        repeat (300) @(posedge clk);
        check(int_n, 1'b0);
        bus(1'b0, RTCT_IDX_CTL2, 8'h00, q);
        check(q[RTCT_CTL2_FLAG], 1'b1);
        wr(RTCT_IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        bus(1'b0, RTCT_IDX_IRQ_STAT, 8'h00, q);
        check(q, 8'h01);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        bus(1'b0, RTCT_IDX_IRQ_STAT, 8'h00, q);
        check(q, 8'h00);
        wr(RTCT_IDX_MODE, 8'h00);
        repeat (2) @(posedge clk);
        check(int_n, 1'b1);
        wr(RTCT_IDX_MODE, 8'h02);
        repeat (2) @(posedge clk);
        check(int_n, 1'b0);
        wr(RTCT_IDX_CTL2, 8'h00);
        repeat (2) @(posedge clk);
        check(int_n, 1'b1);
        measure(8'h01, 8'h07, 2000, w1, p1);
        measure(8'h03, 8'h07, 2000, w3, p3);
        check(near(p3, 3 * p1), 1'b1);
        check(near(2 * w1, p1), 1'b1);
        check(near(w3, p1), 1'b1);
        measure(8'h01, 8'h0f, 20000, w64, p64);
        check(near(p64, 64 * p1), 1'b1);
        check(near(2 * w64, p64), 1'b1);
        wait_int(1'b1, 20000, n);
        bus(1'b0, RTCT_IDX_CTL2, 8'h00, q);
        check(q[RTCT_CTL2_FLAG], 1'b1);
        wr(RTCT_IDX_MODE, 8'h06);
        wr(RTCT_IDX_VALUE, 8'hc8);
        bus(1'b0, RTCT_IDX_VALUE, 8'h00, q);
        check(q == 8'hc8 || q == 8'hc7, 1'b1);
        repeat (10 * p1) @(posedge clk);
        bus(1'b0, RTCT_IDX_VALUE, 8'h00, a);
        bus(1'b0, RTCT_IDX_VALUE, 8'h00, q);
        if (a !== q)
            bus(1'b0, RTCT_IDX_VALUE, 8'h00, q);
        check(near(int'(q), 190), 1'b1);
        wr(RTCT_IDX_MODE, 8'h18);
        conclude();
    end
endmodule
